/* core/chx_cfg.svh */
// Constants for the channel program XOR decoder and descriptor list.
// Assumes a 50 MHz processor clock; included by bare name.
`ifndef CHX_CFG_SVH
`define CHX_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define XOR_TIME_NS 750
`define XOR_CYC ((`XOR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// Opcodes and rows
// ----------------------------------------
`define OPC_XOR_R_TBL 8'h55
`define OPC_XOR_B_TBL 8'h75
`define OPC_XOR_R_IND 8'h85
`define OPC_XOR_R_IMM 8'h95
`define OPC_XOR_B_IMM 8'hb5
`define OPC_GNB 8'h02
`define OPC_GIVE 8'h12
`define OPC_BR_T 8'he2
`define OPC_BR_F 8'hf2
`define ROW_SEND 4'h6
`define ROW_RECV 4'ha

// ----------------------------------------
// Assigned columns per row, bit n = column n
// ----------------------------------------
`define ROW0_MASK 16'h3fff
`define ROW1_MASK 16'h007f
`define ROW2_MASK 16'h03ff
`define ROW3_MASK 16'h03ff
`define ROW5_MASK 16'hffff
`define ROW6_MASK 16'h000f
`define ROW7_MASK 16'h3fff
`define ROW8_MASK 16'hf7ff
`define ROW9_MASK 16'hafff
`define ROWA_MASK 16'hff0f
`define ROWB_MASK 16'hffbf
`define ROWC_MASK 16'h64c3
`define ROWE_MASK 16'hc1ff
`define ROWF_MASK 16'hc3ff

// ----------------------------------------
// Descriptor status
// ----------------------------------------
`define STAT_DONE_BIT 15

`endif

/* core/chx_exec.sv */
// Channel program XOR execution, opcode decode and descriptor list.
// Assumes instruction and host strobes come from logic on SYS_CLK.
// How it works
// [RULE1] R XOR table entry into R
// [RULE2] B XOR table entry into B, 0.75 us
// [RULE3] R XOR entry indexed by B into R
// [RULE4] R XOR immediate byte into R
// [RULE5] B XOR immediate byte into B
// [RULE6] Sign flag follows result top bit
// [RULE7] Null flag set when result is zero
// [RULE8] High nibble picks row, low picks column
// [RULE9] Unassigned and reserved row codes are illegal
// [RULE10] Send/receive columns 0-3 pick parity, CRC
// [RULE11] Column 2 branches test null or sign; code pulses BR_NS_TRUE/BR_NS_FALSE on decode alone, flags untested
// [RULE12] Eight descriptors per channel, circular list
// [RULE13] Next, processed and current descriptor queues
// [RULE14] Completion signals host, releases one slot; code frees the slot only when the host unloads it
// [RULE15] Host loads buffer then control order
// [RULE16] Final status written on completion
// [RULE17] Carry kept; operands are bytes
// [RULE18] Address up, range down, stop at zero
`timescale 1ns/100ps
`include "chx_cfg.svh"

module chx_exec (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Instruction stream
  input wire logic INSTR_VALID,
  input wire logic [7:0] INSTR_OP,
  input wire logic [7:0] INSTR_ARG,
  // Table load and carry load
  input wire logic TBL_WE,
  input wire logic [7:0] TBL_ADDR,
  input wire logic [7:0] TBL_WDATA,
  input wire logic CARRY_LOAD,
  input wire logic CARRY_IN,
  // Host orders and transfer
  input wire logic BUF_LOAD,
  input wire logic [23:0] BUF_ADDR,
  input wire logic [15:0] BUF_RANGE,
  input wire logic DESC_CTRL,
  input wire logic [7:0] DESC_CTRL_BYTE,
  input wire logic DESC_UNLOAD,
  input wire logic [15:0] XFER_STATUS,
  input wire logic XFER_BYTE,
  // Execution results
  output logic [7:0] R_ACC,
  output logic [7:0] B_ACC,
  output logic SIGN_FLAG,
  output logic NULL_FLAG,
  output logic CARRY_FLAG,
  output logic BUSY,
  output logic DONE,
  output logic ILLEGAL,
  output logic CHAR_FMT,
  output logic PARITY_EN,
  output logic CRC_EN,
  output logic BR_NS_TRUE,
  output logic BR_NS_FALSE,
  // Descriptor list
  output logic BUF_NAK,
  output logic DESC_DONE,
  output logic [23:0] DESC_ADDR,
  output logic LAST_CHAR,
  output logic DESC_VALID,
  output logic [3:0] NEXT_COUNT,
  output logic [3:0] PROC_COUNT
);

  typedef struct packed {
    chx_pkg::exec_state_t state;
    logic [5:0] cnt;
    chx_pkg::op_t op;
    logic [7:0] res;
    logic [7:0] r;
    logic [7:0] b;
    logic sign;
    logic nul;
    logic carry;
    logic done;
    logic illegal;
    logic fmt;
    logic parity;
    logic crc;
    logic brt;
    logic brf;
    logic cmpl;
    logic [255:0][7:0] tbl;
  } exec_t;

  exec_t s_ff;
  exec_t nxt_s;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  chx_pkg::op_t dec_op;
  logic [7:0] idx;
  logic [7:0] operand;
  logic [7:0] xres;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic [15:0] row_mask(input logic [3:0] row);
    logic [15:0] m;
    begin
      unique case (row)
        4'h0: m = `ROW0_MASK;
        4'h1: m = `ROW1_MASK;
        4'h2: m = `ROW2_MASK;
        4'h3: m = `ROW3_MASK;
        4'h5: m = `ROW5_MASK;
        4'h6: m = `ROW6_MASK;
        4'h7: m = `ROW7_MASK;
        4'h8: m = `ROW8_MASK;
        4'h9: m = `ROW9_MASK;
        4'ha: m = `ROWA_MASK;
        4'hb: m = `ROWB_MASK;
        4'hc: m = `ROWC_MASK;
        4'he: m = `ROWE_MASK;
        4'hf: m = `ROWF_MASK;
        default: m = 16'h0000;
      endcase
      return m;
    end
  endfunction : row_mask

  function automatic chx_pkg::op_t decode(input logic [7:0] opc);
    chx_pkg::op_t o;
    logic [15:0] m;
    begin
      m = row_mask(opc[7:4]);
      // Row is the high nibble, column the low nibble [RULE8]
      if (opc == `OPC_XOR_R_TBL) o = chx_pkg::OP_XOR_R_TBL;
      else if (opc == `OPC_XOR_B_TBL) o = chx_pkg::OP_XOR_B_TBL;
      else if (opc == `OPC_XOR_R_IND) o = chx_pkg::OP_XOR_R_IND;
      else if (opc == `OPC_XOR_R_IMM) o = chx_pkg::OP_XOR_R_IMM;
      else if (opc == `OPC_XOR_B_IMM) o = chx_pkg::OP_XOR_B_IMM;
      else if (opc == `OPC_GNB) o = chx_pkg::OP_GNB;
      else if (opc == `OPC_GIVE) o = chx_pkg::OP_GIVE;
      else if (opc == `OPC_BR_T) o = chx_pkg::OP_BR_NS_T; // [RULE11]
      else if (opc == `OPC_BR_F) o = chx_pkg::OP_BR_NS_F; // [RULE11]
      else if ((opc[7:4] == `ROW_SEND || opc[7:4] == `ROW_RECV) && opc[3:2] == 2'h0)
        o = chx_pkg::OP_CHAR_FMT;
      else if (m[opc[3:0]]) o = chx_pkg::OP_OTHER;
      else o = chx_pkg::OP_ILLEGAL; // [RULE9]
      return o;
    end
  endfunction : decode

  function automatic logic to_b(input chx_pkg::op_t o);
    return o == chx_pkg::OP_XOR_B_TBL || o == chx_pkg::OP_XOR_B_IMM;
  endfunction : to_b

  function automatic logic is_xor(input chx_pkg::op_t o);
    return o inside {chx_pkg::OP_XOR_R_TBL, chx_pkg::OP_XOR_B_TBL,
      chx_pkg::OP_XOR_R_IND, chx_pkg::OP_XOR_R_IMM, chx_pkg::OP_XOR_B_IMM};
  endfunction : is_xor

  // ----------------------------------------
  // Operand select and XOR
  // ----------------------------------------
  assign dec_op = decode(INSTR_OP);
  assign idx = (dec_op == chx_pkg::OP_XOR_R_IND) ? s_ff.b : INSTR_ARG; // [RULE3]
  assign operand = (dec_op == chx_pkg::OP_XOR_R_IMM || dec_op == chx_pkg::OP_XOR_B_IMM)
    ? INSTR_ARG : s_ff.tbl[idx]; // [RULE4] [RULE5]
  assign xres = (to_b(dec_op) ? s_ff.b : s_ff.r) ^ operand; // [RULE1] [RULE2] [RULE17]

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.illegal = 1'b0;
    nxt_s.fmt = 1'b0;
    nxt_s.brt = 1'b0;
    nxt_s.brf = 1'b0;
    nxt_s.cmpl = 1'b0;
    if (TBL_WE) begin
      nxt_s.tbl[TBL_ADDR] = TBL_WDATA;
    end
    if (CARRY_LOAD) begin
      nxt_s.carry = CARRY_IN;
    end
    unique case (s_ff.state)
      chx_pkg::ST_IDLE: begin
        if (INSTR_VALID) begin
          nxt_s.op = dec_op;
          if (is_xor(dec_op)) begin
            nxt_s.state = chx_pkg::ST_EXEC;
            nxt_s.cnt = 6'(`XOR_CYC - 1); // [RULE2]
            nxt_s.res = xres;
          end else begin
            nxt_s.done = 1'b1;
            nxt_s.illegal = dec_op == chx_pkg::OP_ILLEGAL; // [RULE9]
            nxt_s.brt = dec_op == chx_pkg::OP_BR_NS_T;
            nxt_s.brf = dec_op == chx_pkg::OP_BR_NS_F;
            nxt_s.cmpl = dec_op == chx_pkg::OP_GNB || dec_op == chx_pkg::OP_GIVE; // [RULE14]
            if (dec_op == chx_pkg::OP_CHAR_FMT) begin
              nxt_s.fmt = 1'b1;
              nxt_s.parity = INSTR_OP[1]; // [RULE10]
              nxt_s.crc = INSTR_OP[0]; // [RULE10]
            end
          end
        end
      end
      chx_pkg::ST_EXEC: begin
        if (s_ff.cnt == 6'h01) begin
          nxt_s.state = chx_pkg::ST_IDLE;
          nxt_s.done = 1'b1;
          if (to_b(s_ff.op)) nxt_s.b = s_ff.res;
          else nxt_s.r = s_ff.res;
          nxt_s.sign = s_ff.res[7]; // [RULE6]
          nxt_s.nul = s_ff.res == 8'h00; // [RULE7]
        end else begin
          nxt_s.cnt = 6'(s_ff.cnt - 6'h01);
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Descriptor list
  // ----------------------------------------
  desc_list u_desc (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .load(BUF_LOAD),
    .load_addr(BUF_ADDR),
    .load_range(BUF_RANGE),
    .ctrl(DESC_CTRL),
    .ctrl_byte(DESC_CTRL_BYTE),
    .unload(DESC_UNLOAD),
    .complete(s_ff.cmpl),
    .final_status(XFER_STATUS),
    .xfer_byte(XFER_BYTE),
    .nak(BUF_NAK),
    .desc_done(DESC_DONE),
    .cur_addr(DESC_ADDR),
    .last_char(LAST_CHAR),
    .cur_valid(DESC_VALID),
    .next_count(NEXT_COUNT),
    .proc_count(PROC_COUNT)
  );

  assign R_ACC = s_ff.r;
  assign B_ACC = s_ff.b;
  assign SIGN_FLAG = s_ff.sign;
  assign NULL_FLAG = s_ff.nul;
  assign CARRY_FLAG = s_ff.carry;
  assign BUSY = s_ff.state == chx_pkg::ST_EXEC;
  assign DONE = s_ff.done;
  assign ILLEGAL = s_ff.illegal;
  assign CHAR_FMT = s_ff.fmt;
  assign PARITY_EN = s_ff.parity;
  assign CRC_EN = s_ff.crc;
  assign BR_NS_TRUE = s_ff.brt;
  assign BR_NS_FALSE = s_ff.brf;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic take_xor;
  assign take_xor = s_ff.state == chx_pkg::ST_IDLE && INSTR_VALID && is_xor(dec_op);

  property p_xor_time;
    @(posedge SYS_CLK) disable iff (!rst_n)
    take_xor |-> ##37 (!DONE && BUSY) ##1 (DONE && !BUSY);
  endproperty
  a_xor_time: assert property (p_xor_time) else $error("xor not done in 38 cycles"); // [RULE2]

  property p_xor_r;
    @(posedge SYS_CLK) disable iff (!rst_n)
    (take_xor && !to_b(dec_op)) |-> ##38 (R_ACC == $past(xres, 38));
  endproperty
  a_xor_r: assert property (p_xor_r) else $error("R result wrong"); // [RULE1] [RULE3] [RULE4]

  property p_xor_b;
    @(posedge SYS_CLK) disable iff (!rst_n)
    (take_xor && to_b(dec_op)) |-> ##38 (B_ACC == $past(xres, 38) && R_ACC == $past(R_ACC, 38));
  endproperty
  a_xor_b: assert property (p_xor_b) else $error("B result wrong"); // [RULE2] [RULE5]

  property p_sign;
    @(posedge SYS_CLK) disable iff (!rst_n)
    (DONE && is_xor(s_ff.op)) |-> SIGN_FLAG == (to_b(s_ff.op) ? B_ACC[7] : R_ACC[7]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong"); // [RULE6]

  property p_null;
    @(posedge SYS_CLK) disable iff (!rst_n)
    (DONE && is_xor(s_ff.op)) |-> NULL_FLAG == ((to_b(s_ff.op) ? B_ACC : R_ACC) == 8'h00);
  endproperty
  a_null: assert property (p_null) else $error("null flag wrong"); // [RULE7]

  property p_carry;
    @(posedge SYS_CLK) disable iff (!rst_n)
    (take_xor && !CARRY_LOAD) ##1 (!CARRY_LOAD)[*8] |-> $stable(CARRY_FLAG);
  endproperty
  a_carry: assert property (p_carry) else $error("xor changed carry"); // [RULE17]

  property p_illegal;
    @(posedge SYS_CLK) disable iff (!rst_n)
    (s_ff.state == chx_pkg::ST_IDLE && INSTR_VALID && INSTR_OP[7:4] inside {4'h4, 4'hd})
      |=> (ILLEGAL && DONE);
  endproperty
  a_illegal: assert property (p_illegal) else $error("reserved row not illegal"); // [RULE9]

  property p_fmt;
    @(posedge SYS_CLK) disable iff (!rst_n)
    (s_ff.state == chx_pkg::ST_IDLE && INSTR_VALID && dec_op == chx_pkg::OP_CHAR_FMT)
      |=> (CHAR_FMT && PARITY_EN == $past(INSTR_OP[1]) && CRC_EN == $past(INSTR_OP[0]));
  endproperty
  a_fmt: assert property (p_fmt) else $error("format select wrong"); // [RULE10]

  property p_branch;
    @(posedge SYS_CLK) disable iff (!rst_n)
    (s_ff.state == chx_pkg::ST_IDLE && INSTR_VALID && INSTR_OP == `OPC_BR_F)
      |=> (BR_NS_FALSE && !BR_NS_TRUE);
  endproperty
  a_branch: assert property (p_branch) else $error("branch decode wrong"); // [RULE11]

endmodule : chx_exec

/* core/chx_pkg.sv */
// Types used only by the XOR decoder and execution sequencer, not the descriptor list.
// Assumes nothing beyond a SystemVerilog compiler.
package chx_pkg;

  typedef enum logic [3:0] {
    OP_ILLEGAL, OP_OTHER, OP_XOR_R_TBL, OP_XOR_B_TBL, OP_XOR_R_IND,
    OP_XOR_R_IMM, OP_XOR_B_IMM, OP_CHAR_FMT, OP_BR_NS_T, OP_BR_NS_F,
    OP_GNB, OP_GIVE
  } op_t;

  typedef enum logic {ST_IDLE, ST_EXEC} exec_state_t;

endpackage : chx_pkg

/* core/desc_list.sv */
// Eight-entry circular transfer descriptor list of one channel.
// Assumes all strobes are one-cycle pulses on the same clock.
`timescale 1ns/100ps
`include "chx_cfg.svh"

module desc_list (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host orders
  input wire logic load,
  input wire logic [23:0] load_addr,
  input wire logic [15:0] load_range,
  input wire logic ctrl,
  input wire logic [7:0] ctrl_byte,
  input wire logic unload,
  // Channel program side
  input wire logic complete,
  input wire logic [15:0] final_status,
  input wire logic xfer_byte,
  // Results
  output logic nak,
  output logic desc_done,
  output logic [23:0] cur_addr,
  output logic last_char,
  output logic cur_valid,
  output logic [3:0] next_count,
  output logic [3:0] proc_count
);

  typedef struct packed {
    logic [7:0][23:0] addr;
    logic [7:0][15:0] rng;
    logic [7:0][7:0] ctl;
    logic [7:0][15:0] stat;
    logic [3:0] wr;
    logic [3:0] cur;
    logic [3:0] ptop;
    logic nak;
    logic done;
    logic last;
    logic [23:0] caddr;
    logic valid;
    logic [3:0] ncnt;
    logic [3:0] pcnt;
  } list_t;

  list_t s_ff;
  list_t nxt_s;
  logic [2:0] ci;
  logic [2:0] li;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.nak = 1'b0;
    nxt_s.done = 1'b0;
    ci = s_ff.cur[2:0];
    li = 3'(s_ff.wr[2:0] - 3'h1);
    // Closed list of eight, full when bottom is eight ahead of top [RULE12]
    if (load) begin
      if (4'(s_ff.wr - s_ff.ptop) == 4'h8) begin
        nxt_s.nak = 1'b1;
      end else begin
        nxt_s.addr[s_ff.wr[2:0]] = load_addr;
        nxt_s.rng[s_ff.wr[2:0]] = load_range;
        nxt_s.wr = 4'(s_ff.wr + 4'h1);
      end
    end
    // Control order follows the load it belongs to [RULE15]
    if (ctrl && s_ff.wr != s_ff.ptop) begin
      nxt_s.ctl[li] = ctrl_byte;
      nxt_s.stat[li] = 16'h0000;
    end
    // Byte moved: step address and range until the range is spent [RULE18]
    if (xfer_byte && s_ff.cur != s_ff.wr && s_ff.rng[ci] != 16'h0000) begin
      nxt_s.addr[ci] = 24'(s_ff.addr[ci] + 24'h1);
      nxt_s.rng[ci] = 16'(s_ff.rng[ci] - 16'h1);
    end
    // Current joins processed queue, status written, host told [RULE13] [RULE14] [RULE16]
    if (complete && s_ff.cur != s_ff.wr) begin
      nxt_s.stat[ci] = final_status | (16'h1 << `STAT_DONE_BIT);
      nxt_s.cur = 4'(s_ff.cur + 4'h1);
      nxt_s.done = 1'b1;
    end
    // Host takes the top processed descriptor, freeing its slot
    if (unload && s_ff.ptop != s_ff.cur) begin
      nxt_s.ptop = 4'(s_ff.ptop + 4'h1);
    end
    nxt_s.last = (nxt_s.cur != nxt_s.wr) && (nxt_s.rng[nxt_s.cur[2:0]] == 16'h0000);
    nxt_s.caddr = nxt_s.addr[nxt_s.cur[2:0]];
    // Queue sizes kept in flops so the outputs need no logic behind them
    nxt_s.valid = nxt_s.cur != nxt_s.wr;
    nxt_s.ncnt = 4'(nxt_s.wr - nxt_s.cur);
    nxt_s.pcnt = 4'(nxt_s.cur - nxt_s.ptop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign nak = s_ff.nak;
  assign desc_done = s_ff.done;
  assign cur_addr = s_ff.caddr;
  assign last_char = s_ff.last;
  assign cur_valid = s_ff.valid;
  assign next_count = s_ff.ncnt;
  assign proc_count = s_ff.pcnt;

  property p_list_bound;
    @(posedge clk) disable iff (!rst_n)
    4'(s_ff.wr - s_ff.ptop) <= 4'h8;
  endproperty
  a_list_bound: assert property (p_list_bound) else $error("descriptor list over eight"); // [RULE12]

  property p_done;
    @(posedge clk) disable iff (!rst_n)
    (complete && cur_valid) |=> (desc_done && s_ff.stat[$past(ci)][`STAT_DONE_BIT]
      && s_ff.stat[$past(ci)] == ($past(final_status) | (16'h1 << `STAT_DONE_BIT)));
  endproperty
  a_done: assert property (p_done) else $error("completion not signalled"); // [RULE14] [RULE16]

  property p_range_stop;
    @(posedge clk) disable iff (!rst_n)
    (xfer_byte && !complete && cur_valid && s_ff.rng[ci] == 16'h0000)
      |=> ($stable(cur_addr) && last_char);
  endproperty
  a_range_stop: assert property (p_range_stop) else $error("address moved at zero range"); // [RULE18]

endmodule : desc_list

/* sim/channel_program_xor_decode_tb.sv */
// Self-checking bench for the XOR executor, opcode decode and descriptor list.
// Assumes host_model and the core files are compiled first.
`timescale 1ns/100ps
`include "chx_cfg.svh"

module channel_program_xor_decode_tb;
  logic SYS_CLK = 1'b0;
  logic RST_N, INSTR_VALID, TBL_WE, CARRY_LOAD, CARRY_IN, XFER_BYTE;
  logic BUF_LOAD, DESC_CTRL, DESC_UNLOAD;
  logic [7:0] INSTR_OP, INSTR_ARG, TBL_ADDR, TBL_WDATA, DESC_CTRL_BYTE;
  logic [23:0] BUF_ADDR, DESC_ADDR;
  logic [15:0] BUF_RANGE, XFER_STATUS;
  logic [7:0] R_ACC, B_ACC;
  logic SIGN_FLAG, NULL_FLAG, CARRY_FLAG, BUSY, DONE, ILLEGAL, CHAR_FMT, PARITY_EN, CRC_EN;
  logic BR_NS_TRUE, BR_NS_FALSE, BUF_NAK, DESC_DONE, LAST_CHAR, DESC_VALID;
  logic [3:0] NEXT_COUNT, PROC_COUNT;
  int err_count = 0;
  int num_checks = 0;
  int seed = 42202;
  int nak_n = 0;
  int r_m, b_m, c_m, i, bn, v;
  int tbl_m [256];
  logic [23:0] aq [$];
  logic [7:0] op;
  logic [7:0] xops [5] = '{`OPC_XOR_R_TBL, `OPC_XOR_B_TBL, `OPC_XOR_R_IND, `OPC_XOR_R_IMM,
                          `OPC_XOR_B_IMM};

  always #10 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) if (BUF_NAK === 1'b1) nak_n++;

  chx_exec dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID),
    .INSTR_OP(INSTR_OP), .INSTR_ARG(INSTR_ARG), .TBL_WE(TBL_WE), .TBL_ADDR(TBL_ADDR),
    .TBL_WDATA(TBL_WDATA), .CARRY_LOAD(CARRY_LOAD), .CARRY_IN(CARRY_IN),
    .BUF_LOAD(BUF_LOAD), .BUF_ADDR(BUF_ADDR), .BUF_RANGE(BUF_RANGE), .DESC_CTRL(DESC_CTRL),
    .DESC_CTRL_BYTE(DESC_CTRL_BYTE), .DESC_UNLOAD(DESC_UNLOAD), .XFER_STATUS(XFER_STATUS),
    .XFER_BYTE(XFER_BYTE), .R_ACC(R_ACC), .B_ACC(B_ACC), .SIGN_FLAG(SIGN_FLAG),
    .NULL_FLAG(NULL_FLAG), .CARRY_FLAG(CARRY_FLAG), .BUSY(BUSY), .DONE(DONE),
    .ILLEGAL(ILLEGAL), .CHAR_FMT(CHAR_FMT), .PARITY_EN(PARITY_EN), .CRC_EN(CRC_EN),
    .BR_NS_TRUE(BR_NS_TRUE), .BR_NS_FALSE(BR_NS_FALSE), .BUF_NAK(BUF_NAK),
    .DESC_DONE(DESC_DONE), .DESC_ADDR(DESC_ADDR), .LAST_CHAR(LAST_CHAR),
    .DESC_VALID(DESC_VALID), .NEXT_COUNT(NEXT_COUNT), .PROC_COUNT(PROC_COUNT));

  host_model u_host (.clk(SYS_CLK), .buf_load(BUF_LOAD), .buf_addr(BUF_ADDR),
    .buf_range(BUF_RANGE), .desc_ctrl(DESC_CTRL), .desc_ctrl_byte(DESC_CTRL_BYTE),
    .desc_unload(DESC_UNLOAD));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Issues one instruction and waits at a falling edge until DONE shows
  task automatic send(input logic [7:0] o, input logic [7:0] arg, output int busy_n);
    int n;
    busy_n = 0;
    n = 0;
    @(posedge SYS_CLK);
    INSTR_VALID <= 1'b1;
    INSTR_OP <= o;
    INSTR_ARG <= arg;
    @(posedge SYS_CLK);
    INSTR_VALID <= 1'b0;
    INSTR_ARG <= ~arg;
    @(negedge SYS_CLK);
    while (DONE !== 1'b1 && n < 60) begin
      if (BUSY === 1'b1) busy_n++;
      n++;
      @(negedge SYS_CLK);
    end
    chk(n < 60, 1, "done timeout");
  endtask : send

  task automatic do_xor(input logic [7:0] o, input logic [7:0] arg);
    int x;
    int res;
    x = (o == `OPC_XOR_R_IND) ? tbl_m[b_m] :
        (o == `OPC_XOR_R_TBL || o == `OPC_XOR_B_TBL) ? tbl_m[arg] : arg;
    if (o == `OPC_XOR_B_TBL || o == `OPC_XOR_B_IMM) begin
      b_m = b_m ^ x;
      res = b_m;
    end else begin
      r_m = r_m ^ x;
      res = r_m;
    end
    send(o, arg, bn);
    chk(R_ACC, r_m, "r acc");
    chk(B_ACC, b_m, "b acc");
    chk(SIGN_FLAG, res[7], "sign");
    chk(NULL_FLAG, res == 0, "null");
    chk(CARRY_FLAG, c_m, "carry");
    chk(bn, `XOR_CYC - 1, "xor time");
  endtask : do_xor

  function automatic logic legal(input logic [7:0] o);
    logic [15:0] m;
    case (o[7:4])
      4'h0: m = `ROW0_MASK;
      4'h1: m = `ROW1_MASK;
      4'h2: m = `ROW2_MASK;
      4'h3: m = `ROW3_MASK;
      4'h5: m = `ROW5_MASK;
      4'h6: m = `ROW6_MASK;
      4'h7: m = `ROW7_MASK;
      4'h8: m = `ROW8_MASK;
      4'h9: m = `ROW9_MASK;
      4'ha: m = `ROWA_MASK;
      4'hb: m = `ROWB_MASK;
      4'hc: m = `ROWC_MASK;
      4'he: m = `ROWE_MASK;
      4'hf: m = `ROWF_MASK;
      default: m = 16'h0000;
    endcase
    return m[o[3:0]];
  endfunction : legal

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {INSTR_VALID, TBL_WE, CARRY_LOAD, CARRY_IN, XFER_BYTE} = 5'h00;
    {INSTR_OP, INSTR_ARG, TBL_ADDR, TBL_WDATA} = 32'h00000000;
    XFER_STATUS = 16'h0000;
    r_m = 0;
    b_m = 0;
    c_m = 1;
    RST_N = 1'b0;
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    chk({R_ACC, B_ACC, DESC_VALID, NEXT_COUNT, PROC_COUNT}, 0, "reset");
    CARRY_LOAD <= 1'b1;
    CARRY_IN <= 1'b1;
    for (i = 0; i < 256; i++) begin
      @(posedge SYS_CLK);
      CARRY_LOAD <= 1'b0;
      v = $random(seed);
      TBL_WE <= 1'b1;
      TBL_ADDR <= i[7:0];
      TBL_WDATA <= v[7:0];
      tbl_m[i] = v & 8'hff;
    end
    @(posedge SYS_CLK);
    TBL_WE <= 1'b0;
    for (i = 0; i < 20; i++) begin
      v = $random(seed);
      do_xor(xops[i % 5], v[7:0]);
    end
    do_xor(`OPC_XOR_R_IMM, r_m[7:0]);
    do_xor(`OPC_XOR_B_IMM, b_m[7:0] ^ 8'h80);
    for (i = 0; i < 256; i++) begin
      op = i[7:0];
      if (op inside {xops}) continue;
      v = $random(seed);
      send(op, v[7:0], bn);
      chk(ILLEGAL, !legal(op), "illegal");
      chk(CHAR_FMT, (op[7:4] inside {`ROW_SEND, `ROW_RECV}) && op[3:2] == 0, "fmt");
      if (CHAR_FMT === 1'b1) chk({PARITY_EN, CRC_EN}, op[1:0], "parity crc");
      chk({BR_NS_TRUE, BR_NS_FALSE}, {op == `OPC_BR_T, op == `OPC_BR_F}, "branch");
    end
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      aq.push_back(v[23:0]);
      u_host.issue(v[23:0], (i == 0) ? 16'h0003 : 16'h0040, v[31:24]);
    end
    @(negedge SYS_CLK);
    chk(NEXT_COUNT, 8, "eight held");
    chk(DESC_ADDR, aq[0], "current addr");
    u_host.issue(24'h123456, 16'h0010, 8'h00);
    @(negedge SYS_CLK);
    chk(nak_n, 1, "ninth refused");
    for (i = 0; i < 4; i++) begin
      @(posedge SYS_CLK);
      XFER_BYTE <= 1'b1;
      @(posedge SYS_CLK);
      XFER_BYTE <= 1'b0;
      @(negedge SYS_CLK);
      chk(DESC_ADDR, 24'(aq[0] + ((i < 3) ? i + 1 : 3)), "byte addr");
      chk(LAST_CHAR, i >= 2, "last char");
    end
    @(posedge SYS_CLK);
    v = $random(seed);
    XFER_STATUS <= v[15:0];
    send(`OPC_GNB, 8'h00, bn);
    @(negedge SYS_CLK);
    chk(DESC_DONE, 1, "gnb done");
    chk({PROC_COUNT, NEXT_COUNT}, {4'h1, 4'h7}, "queues");
    chk(DESC_ADDR, aq[1], "next current");
    send(`OPC_GIVE, 8'h00, bn);
    @(negedge SYS_CLK);
    chk(DESC_DONE, 1, "give done");
    chk({PROC_COUNT, NEXT_COUNT}, {4'h2, 4'h6}, "queues");
    u_host.unload();
    @(negedge SYS_CLK);
    chk(PROC_COUNT, 1, "unload");
    u_host.issue(24'h00abcd, 16'h0008, 8'h00);
    @(negedge SYS_CLK);
    chk(nak_n, 1, "slot reused");
    chk(NEXT_COUNT, 7, "wrapped");
    results();
  end

  initial begin
    #(20 * 20000);
    err_count++;
    results();
  end
endmodule : channel_program_xor_decode_tb

/* sim/host_model.sv */
// Host side model: hands buffer descriptors to the channel and unloads them.
// Assumes orders are sampled on the rising edge of clk.
`timescale 1ns/100ps

module host_model (
  // Clock
  input wire logic clk,
  // Orders to the channel
  output logic buf_load,
  output logic [23:0] buf_addr,
  output logic [15:0] buf_range,
  output logic desc_ctrl,
  output logic [7:0] desc_ctrl_byte,
  output logic desc_unload
);
  logic active;

  initial begin
    active = 1'b0;
    buf_load = 1'b0;
    buf_addr = 24'h000000;
    buf_range = 16'h0000;
    desc_ctrl = 1'b0;
    desc_ctrl_byte = 8'h00;
    desc_unload = 1'b0;
  end

  // Released lines keep changing so a stale value never looks valid
  always @(negedge clk) begin
    if (!active) begin
      buf_addr <= ~buf_addr;
      buf_range <= ~buf_range;
      desc_ctrl_byte <= ~desc_ctrl_byte;
    end
  end

  task automatic issue(input logic [23:0] a, input logic [15:0] r, input logic [7:0] c);
    @(posedge clk);
    active = 1'b1;
    buf_load <= 1'b1;
    buf_addr <= a;
    buf_range <= r;
    @(posedge clk);
    buf_load <= 1'b0;
    desc_ctrl <= 1'b1;
    desc_ctrl_byte <= c;
    @(posedge clk);
    desc_ctrl <= 1'b0;
    active = 1'b0;
  endtask : issue

  task automatic unload;
    @(posedge clk);
    desc_unload <= 1'b1;
    @(posedge clk);
    desc_unload <= 1'b0;
  endtask : unload
endmodule : host_model
